// ### hdl/lis_defs.vh
// Register map, field positions and reset values of the interrupt cause bank.
// Included by the cause bank only; definitions only.
`ifndef LIS_DEFS_VH
`define LIS_DEFS_VH

// Word offsets on the Wishbone slave (byte addresses)
`define LIS_OFF_CAUSE      8'h10
`define LIS_OFF_MASK       8'h14
`define LIS_OFF_ENABLE     8'h18
`define LIS_OFF_CONTROL    8'h1c

// Cause bit positions
`define LIS_BIT_PAUSE_END  27
`define LIS_BIT_PAUSE_BEG  26
`define LIS_BIT_TX_RST     25
`define LIS_BIT_RX_RST     24
`define LIS_BIT_PARITY     23
`define LIS_BIT_SYSERR     22
`define LIS_BIT_MABORT     21
`define LIS_BIT_TABORT     20
`define LIS_BIT_RXS_OVR    16
`define LIS_BIT_SUMMARY    15
`define LIS_BIT_SWREQ      12
`define LIS_BIT_TX_URN     10
`define LIS_BIT_TX_IDLE    9
`define LIS_BIT_TX_ERR     8
`define LIS_BIT_TX_DESC    7
`define LIS_BIT_TX_OK      6
`define LIS_BIT_RX_ORN     5
`define LIS_BIT_RX_IDLE    4
`define LIS_BIT_RX_EARLY   3
`define LIS_BIT_RX_ERR     2
`define LIS_BIT_RX_DESC    1
`define LIS_BIT_RX_OK      0

// Summary covers bits 25 down to 16
`define LIS_SUM_HI         25
`define LIS_SUM_LO         16

// Bits that hold a latched event (reserved and summary bits excluded)
`define LIS_EVENT_MASK     28'hff117ff
// Reset values
`define LIS_CAUSE_RST      28'h3008000
`define LIS_MASK_RST       28'h0000000
`define LIS_ENABLE_RST     1'b0

// Control register field: software request bit
`define LIS_CTL_SWREQ      0

`endif

// ### hdl/lis_edge_det.v
// Rising-edge detector for level inputs on the core clock.
// Assumes inputs are already synchronous to core_clk.
`default_nettype none

module lis_edge_det #(
	parameter WIDTH = 2
) (
	input  wire             core_clk,
	input  wire             arst_n,
	input  wire [WIDTH-1:0] level_in,
	output wire [WIDTH-1:0] rise_out
);

	reg [WIDTH-1:0] prev_reg;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			prev_reg <= {WIDTH{1'b0}};
		else
			prev_reg <= level_in;
	end

	assign rise_out = level_in & ~prev_reg;

endmodule // lis_edge_det

`default_nettype wire

// ### hdl/lis_cause_bank.v
// Interrupt cause bank of a bus-mastering Fast Ethernet controller: bits 27..0,
// with mask, global enable and control registers on a classic Wishbone slave.
// Assumes event pulses come from logic on core_clk; the parity and system-error
// levels are synchronous too. Soft reset is a one-cycle pulse on core_clk.
`include "lis_defs.vh"
`default_nettype none

module lis_cause_bank (
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire        soft_rst,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Event pulses, one core_clk cycle each
	input  wire        pause_end_evt,
	input  wire        pause_begin_evt,
	input  wire        tx_reset_done_evt,
	input  wire        rx_reset_done_evt,
	input  wire        master_abort_evt,
	input  wire        target_abort_evt,
	input  wire        rx_status_fifo_ovr_evt,
	input  wire        tx_fifo_starved_evt,
	input  wire        tx_frame_failed_evt,
	input  wire        tx_desc_done_evt,
	input  wire        tx_desc_descriptor_interrupt_request_bit_req,
	input  wire        tx_frame_good_evt,
	input  wire        rx_fifo_overflow_evt,
	input  wire        rx_threshold_evt,
	input  wire        rx_packet_start,
	input  wire        rx_frame_failed_evt,
	input  wire        rx_desc_done_evt,
	input  wire        rx_desc_descriptor_interrupt_request_bit_req,
	input  wire        rx_frame_good_evt,
	// State levels
	input  wire        tx_idle_state,
	input  wire        rx_idle_state,
	input  wire        parity_fault_flag,
	input  wire        system_fault_sent_flag,
	// Interrupt out
	output reg         host_interrupt_line,
	output wire        software_request_flag
);

	// ==========================================================
	// Local registers
	// ==========================================================
	reg [27:0] cause_reg;
	reg [27:0] cause_next;
	reg [27:0] interrupt_mask_bank_reg;
	reg        global_interrupt_gate_reg;
	reg        swreq_reg;
	reg        tx_idle_prev_reg;
	reg        rx_idle_prev_reg;
	reg        rx_early_done_reg;

	wire       wb_req;
	wire       wb_rd;
	wire       wb_wr;
	wire       rd_cause;
	wire [27:0] cause_view;
	wire [27:0] event_set;
	wire [2:0] lvl_rise;
	wire       swreq_set;

	assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_rd    = wb_req & ~wb_we_i;
	assign wb_wr    = wb_req & wb_we_i;
	assign rd_cause = wb_rd & (wb_adr_i == `LIS_OFF_CAUSE);
	assign software_request_flag = swreq_reg;

	// ==========================================================
	// Level edges
	// ==========================================================
	// Software request register arrives here as a level so one edge helper serves it, parity and system error
	assign swreq_set = wb_wr & (wb_adr_i == `LIS_OFF_CONTROL) & wb_sel_i[0]
		& wb_dat_i[`LIS_CTL_SWREQ];

	lis_edge_det #(
		.WIDTH (3)
	) u_edges (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.level_in ({parity_fault_flag, system_fault_sent_flag, swreq_reg}),
		.rise_out (lvl_rise)
	);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_idle_prev_reg  <= 1'b1;
			rx_idle_prev_reg  <= 1'b1;
			rx_early_done_reg <= 1'b0;
		end else begin
			tx_idle_prev_reg <= tx_idle_state;
			rx_idle_prev_reg <= rx_idle_state;
			if (rx_packet_start)
				rx_early_done_reg <= 1'b0;
			else if (rx_threshold_evt)
				rx_early_done_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Event vector
	// ==========================================================
	// Event sources, pause at bit 27 down to receive good at bit 0; reserved bits tie to zero
	assign event_set[`LIS_BIT_PAUSE_END] = pause_end_evt;
	assign event_set[`LIS_BIT_PAUSE_BEG] = pause_begin_evt;
	assign event_set[`LIS_BIT_TX_RST]    = tx_reset_done_evt;
	assign event_set[`LIS_BIT_RX_RST]    = rx_reset_done_evt;
	assign event_set[`LIS_BIT_PARITY]    = lvl_rise[2];
	assign event_set[`LIS_BIT_SYSERR]    = lvl_rise[1];
	assign event_set[`LIS_BIT_MABORT]    = master_abort_evt;
	assign event_set[`LIS_BIT_TABORT]    = target_abort_evt;
	assign event_set[19:17]              = 3'h0;
	assign event_set[`LIS_BIT_RXS_OVR]   = rx_status_fifo_ovr_evt;
	assign event_set[15:13]              = 3'h0;
	assign event_set[`LIS_BIT_SWREQ]     = lvl_rise[0];
	assign event_set[11]                 = 1'b0;
	assign event_set[`LIS_BIT_TX_URN]    = tx_fifo_starved_evt;
	assign event_set[`LIS_BIT_TX_IDLE]   = tx_idle_state & ~tx_idle_prev_reg;
	assign event_set[`LIS_BIT_TX_ERR]    = tx_frame_failed_evt;
	assign event_set[`LIS_BIT_TX_DESC]   = tx_desc_done_evt & tx_desc_descriptor_interrupt_request_bit_req;
	assign event_set[`LIS_BIT_TX_OK]     = tx_frame_good_evt;
	assign event_set[`LIS_BIT_RX_ORN]    = rx_fifo_overflow_evt;
	assign event_set[`LIS_BIT_RX_IDLE]   = rx_idle_state & ~rx_idle_prev_reg;
	assign event_set[`LIS_BIT_RX_EARLY]  = rx_threshold_evt & ~rx_early_done_reg & ~rx_packet_start;
	assign event_set[`LIS_BIT_RX_ERR]    = rx_frame_failed_evt;
	assign event_set[`LIS_BIT_RX_DESC]   = rx_desc_done_evt & rx_desc_descriptor_interrupt_request_bit_req;
	assign event_set[`LIS_BIT_RX_OK]     = rx_frame_good_evt;

	// ==========================================================
	// Cause latch
	// ==========================================================
	// Set wins over the read clear so an event landing on the read is kept
	always @* begin
		cause_next = cause_reg;
		if (rd_cause)
			cause_next = 28'h0;
		cause_next = (cause_next | event_set) & `LIS_EVENT_MASK;
	end

	assign cause_view = {cause_reg[27:16], |cause_reg[`LIS_SUM_HI:`LIS_SUM_LO], cause_reg[14:0]}
		& (`LIS_EVENT_MASK | (28'h1 << `LIS_BIT_SUMMARY));

	// ==========================================================
	// Registers and bus slave
	// ==========================================================
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_reg                 <= `LIS_CAUSE_RST;
			interrupt_mask_bank_reg   <= `LIS_MASK_RST;
			global_interrupt_gate_reg <= `LIS_ENABLE_RST;
			swreq_reg                 <= 1'b0;
			wb_ack_o                  <= 1'b0;
			wb_dat_o                  <= 32'h0;
			host_interrupt_line       <= 1'b0;
		end else if (soft_rst) begin
			cause_reg                 <= `LIS_CAUSE_RST;
			interrupt_mask_bank_reg   <= `LIS_MASK_RST;
			global_interrupt_gate_reg <= `LIS_ENABLE_RST;
			swreq_reg                 <= 1'b0;
			wb_ack_o                  <= 1'b0;
			wb_dat_o                  <= 32'h0;
			host_interrupt_line       <= 1'b0;
		end else begin
			wb_ack_o  <= wb_req;
			cause_reg <= cause_next;
			// Cause offset absent from write decode
			if (wb_wr) begin
				case (wb_adr_i)
				`LIS_OFF_MASK: begin
					if (wb_sel_i[0]) interrupt_mask_bank_reg[7:0]   <= wb_dat_i[7:0];
					if (wb_sel_i[1]) interrupt_mask_bank_reg[15:8]  <= wb_dat_i[15:8];
					if (wb_sel_i[2]) interrupt_mask_bank_reg[23:16] <= wb_dat_i[23:16];
					if (wb_sel_i[3]) interrupt_mask_bank_reg[27:24] <= wb_dat_i[27:24];
				end
				`LIS_OFF_ENABLE: begin
					if (wb_sel_i[0]) global_interrupt_gate_reg <= wb_dat_i[0];
				end
				`LIS_OFF_CONTROL: begin
					if (wb_sel_i[0]) swreq_reg <= wb_dat_i[`LIS_CTL_SWREQ];
				end
				default: begin
				end
				endcase
			end
			if (wb_rd) begin
				case (wb_adr_i)
				`LIS_OFF_CAUSE:   wb_dat_o <= {4'h0, cause_view};
				`LIS_OFF_MASK:    wb_dat_o <= {4'h0, interrupt_mask_bank_reg};
				`LIS_OFF_ENABLE:  wb_dat_o <= {31'h0, global_interrupt_gate_reg};
				`LIS_OFF_CONTROL: wb_dat_o <= {31'h0, swreq_reg};
				// Unmapped offsets read zero and still acknowledge
				default:          wb_dat_o <= 32'h0;
				endcase
			end
			host_interrupt_line <= global_interrupt_gate_reg
				& (|(cause_view & interrupt_mask_bank_reg));
		end
	end

	// swreq_set is the write-one strobe of the request bit; kept for clarity of decode
	wire unused_swreq_set = swreq_set;

endmodule // lis_cause_bank

`default_nettype wire

// ### tb/lis_cause_monitor.sv
// Port checker for the interrupt cause bank.
// Assumes one core_clk domain and a classic Wishbone master.
`default_nettype none
module lis_cause_monitor (
	input wire logic	core_clk,
	input wire logic	arst_n,
	input wire logic	soft_rst,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [7:0]	wb_adr_i,
	input wire logic [3:0]	wb_sel_i,
	input wire logic [31:0]	wb_dat_i,
	input wire logic [31:0]	wb_dat_o,
	input wire logic	wb_ack_o,
	input wire logic	host_interrupt_line,
	input wire logic	software_request_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// ======
	// Helpers
	wire	req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire	rd_cause = wb_ack_o && !wb_we_i && wb_adr_i == 8'h10;
	// Writes land on the edge that takes the request, the same edge that raises ack
	wire	wr_ctl = req && wb_we_i && wb_adr_i == 8'h1c && wb_sel_i[0];
	logic	en_reg;
	// Shadow of the global gate, so the line can be judged without seeing inside
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n || soft_rst)
			en_reg <= 1'b0;
		else if (req && wb_we_i && wb_adr_i == 8'h18 && wb_sel_i[0])
			en_reg <= wb_dat_i[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// ======
	// Assertions
	chk_ack_latency: assert property (req |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_no_spur_ack: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	chk_irq_gate: assert property ($past(!en_reg) |-> !host_interrupt_line)
		else $error("interrupt line high while gate closed");
	chk_sw_flag: assert property (wr_ctl |=> software_request_flag == $past(wb_dat_i[0]))
		else $error("software request flag not written");
	chk_sw_hold: assert property (!wr_ctl && !soft_rst |=> $stable(software_request_flag))
		else $error("software request flag changed alone");
	chk_reserved_zero: assert property (rd_cause |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[19:17] == 3'h0
		&& wb_dat_o[14:13] == 2'h0 && !wb_dat_o[11])
		else $error("reserved cause bits not zero");
	chk_summary_or: assert property (rd_cause |-> wb_dat_o[15] == |wb_dat_o[25:16])
		else $error("summary bit wrong");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:4] != 4'h1 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	cover property (rd_cause && wb_dat_o != 32'h0);
	cover property ($rose(host_interrupt_line));
	cover property ($rose(software_request_flag));
endmodule // lis_cause_monitor

bind lis_cause_bank lis_cause_monitor u_mon (.core_clk, .arst_n, .soft_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_interrupt_line, .software_request_flag);
`default_nettype wire

// ### tb/lis_host_model.sv
// Host software model: a classic Wishbone master, one cycle at a time.
// Assumes the slave acks on core_clk; the bench calls xfer.
`default_nettype none
module lis_host_model (
	input wire logic	core_clk,
	input wire logic	ack,
	output var logic	cyc,
	output var logic	stb,
	output var logic	we,
	output var logic [7:0]	adr,
	output var logic [3:0]	sel,
	output var logic [31:0]	dat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {cyc, stb, we, adr, sel, dat} = 47'h0;
	// ======
	// Bus cycle; released address and data lines show inverted values, not stale ones
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		do @(posedge core_clk); while (!ack);
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a;
		dat <= ~d;
	endtask
endmodule // lis_host_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the interrupt cause bank.
// Assumes the host model is the only bus master.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic		core_clk = 1'b0, arst_n = 1'b0, soft_rst = 1'b0;
	logic		cyc, stb, we, ack, irq, swf, ps = 1'b0, dreq = 1'b1;
	logic [7:0]	adr;
	logic [3:0]	sel;
	logic [3:0]	lv = 4'h3;
	logic [31:0]	dw, dr;
	logic [15:0]	ev = 16'h0, seed = 16'h0028;
	logic [31:0]	exp_q[$];
	int		err_count = 0, n_compared = 0, cycles = 0;
	int		bt[16] = '{27, 26, 25, 24, 21, 20, 16, 10, 8, 7, 6, 5, 3, 2, 1, 0};

	always #12.5 core_clk = ~core_clk;

	lis_host_model u_host (.core_clk, .ack, .cyc, .stb, .we, .adr, .sel, .dat(dw));
	lis_cause_bank i_lis_cause_bank (.core_clk, .arst_n, .soft_rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.pause_end_evt(ev[0]), .pause_begin_evt(ev[1]), .tx_reset_done_evt(ev[2]), .rx_reset_done_evt(ev[3]),
		.master_abort_evt(ev[4]), .target_abort_evt(ev[5]), .rx_status_fifo_ovr_evt(ev[6]),
		.tx_fifo_starved_evt(ev[7]), .tx_frame_failed_evt(ev[8]), .tx_desc_done_evt(ev[9]),
		.tx_desc_descriptor_interrupt_request_bit_req(dreq), .tx_frame_good_evt(ev[10]), .rx_fifo_overflow_evt(ev[11]),
		.rx_threshold_evt(ev[12]), .rx_packet_start(ps), .rx_frame_failed_evt(ev[13]),
		.rx_desc_done_evt(ev[14]), .rx_desc_descriptor_interrupt_request_bit_req(dreq), .rx_frame_good_evt(ev[15]),
		.tx_idle_state(lv[1]), .rx_idle_state(lv[0]), .parity_fault_flag(lv[3]),
		.system_fault_sent_flag(lv[2]), .host_interrupt_line(irq), .software_request_flag(swf));

	// ======
	// Helpers
	function automatic logic [31:0] expect_of(logic [15:0] v);
		logic [31:0] e;
		e = 32'h0;
		for (int i = 0; i < 16; i++)
			if (v[i]) e[bt[i]] = 1'b1;
		e[15] = |e[25:16];
		return e;
	endfunction
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d);
	endtask
	// Packet start goes a cycle ahead so the threshold event is re-armed
	task automatic pulse(input logic [15:0] v, input logic st);
		@(posedge core_clk) ps <= st;
		@(posedge core_clk) ps <= 1'b0;
		ev <= v;
		@(posedge core_clk) ev <= 16'h0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] e);
		n_compared++;
		if (got !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, e);
		end
	endtask
	task automatic cmp_irq(input logic e);
		cmp({31'h0, irq}, {31'h0, e});
	endtask
	task automatic wrap_up;
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		if (ack && !we) cmp(dr, exp_q.pop_front());
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			wrap_up();
		end
	end

	// ======
	// Scenarios
	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(8'h10, 32'h0300_8000);
		rd(8'h10, 32'h0);
		for (int i = 0; i < 16; i++) begin
			pulse(16'h1 << i, 1'b1);
			rd(8'h10, expect_of(16'h1 << i));
		end
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			pulse(seed, 1'b1);
			rd(8'h10, expect_of(seed));
		end
		pulse(16'h1000, 1'b1);
		rd(8'h10, 32'h8);
		pulse(16'h1000, 1'b0);
		rd(8'h10, 32'h0);
		@(posedge core_clk) lv <= 4'h0;
		repeat (2) @(posedge core_clk);
		lv <= 4'hf;
		repeat (3) @(posedge core_clk);
		rd(8'h10, 32'h00c0_8210);
		wr(8'h1c, 32'h1);
		repeat (2) @(posedge core_clk);
		cmp({31'h0, swf}, 32'h1);
		rd(8'h10, 32'h1000);
		wr(8'h1c, 32'h0);
		pulse(16'h8000, 1'b0);
		wr(8'h10, 32'hffff_ffff);
		rd(8'h10, 32'h1);
		rd(8'h20, 32'h0);
		wr(8'h14, 32'h1);
		rd(8'h14, 32'h1);
		pulse(16'h8000, 1'b0);
		cmp_irq(1'b0);
		wr(8'h18, 32'h1);
		repeat (3) @(posedge core_clk);
		cmp_irq(1'b1);
		wr(8'h18, 32'h0);
		repeat (3) @(posedge core_clk);
		cmp_irq(1'b0);
		rd(8'h14, 32'h1);
		rd(8'h10, 32'h1);
		wr(8'h18, 32'h1);
		pulse(16'h4000, 1'b0);
		cmp_irq(1'b0);
		rd(8'h10, 32'h2);
		@(posedge core_clk) soft_rst <= 1'b1;
		@(posedge core_clk) soft_rst <= 1'b0;
		rd(8'h10, 32'h0300_8000);
		rd(8'h18, 32'h0);
		repeat (2) @(posedge core_clk);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
